// [hw/dpc_pkg.sv]
package dpc_pkg;
  localparam int DPC_AW = 5;
  localparam int DPC_DW = 32;
  localparam int DPC_N_W = 5;
  localparam int DPC_K_W = 24;
  localparam int DPC_OD_W = 5;
  localparam int DPC_PD_W = 4;
  localparam int DPC_ACC_W = 32;
  // Register byte offsets
  localparam logic [DPC_AW-1:0] DPC_OFF_CTRL = 5'h00;
  localparam logic [DPC_AW-1:0] DPC_OFF_STAT = 5'h04;
  localparam logic [DPC_AW-1:0] DPC_OFF_L2CFG = 5'h08;
  localparam logic [DPC_AW-1:0] DPC_OFF_L2K = 5'h0C;
  localparam logic [DPC_AW-1:0] DPC_OFF_L3CFG = 5'h10;
  localparam logic [DPC_AW-1:0] DPC_OFF_L3K = 5'h14;
  localparam logic [DPC_AW-1:0] DPC_OFF_DIV = 5'h18;
  // Control register fields
  localparam int DPC_CTRL_EN2 = 0;
  localparam int DPC_CTRL_EN3 = 1;
  localparam int DPC_CTRL_REFSEL = 2;
  localparam int DPC_CTRL_FLL3 = 3;
  localparam int DPC_CTRL_SEQ = 4;
  localparam int DPC_CTRL_W = 5;
  // Reference select 0 = internal oscillator, 1 = master clock pin
  localparam logic [DPC_CTRL_W-1:0] DPC_CTRL_RST = 5'h10;
  // Loop configuration fields
  localparam int DPC_CFG_N_LSB = 0;
  localparam int DPC_CFG_FRAC = 8;
  localparam int DPC_CFG_OD_LSB = 16;
  localparam logic [DPC_N_W-1:0] DPC_N_RST = 5'h08;
  localparam logic [DPC_OD_W-1:0] DPC_OD_RST = 5'h01;
  localparam logic [DPC_K_W-1:0] DPC_K_RST = 24'h000000;
  // Post divider fields
  localparam int DPC_DIV_CO2_LSB = 0;
  localparam int DPC_DIV_CO3_LSB = 8;
  localparam int DPC_DIV_SYS_LSB = 16;
  localparam logic [DPC_PD_W-1:0] DPC_PD_RST = 4'h0;
  typedef enum logic [2:0] {
    DPC_OFF = 3'b001,
    DPC_ARM = 3'b010,
    DPC_RUN = 3'b100
  } dpc_loop_state_t;
endpackage

// [hw/dpc_dual_loop_ctrl.sv]
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// What this block does
// - Two loops, each with its own independent enable bit.
// - Reference select picks master clock pin or internal oscillator.
// - Reference select resets to the internal oscillator for both loops.
// - Select bit routes the frequency locked loop output to the third loop.
// - Sync sequencer aligns loop start; on by default, has an enable bit.
// - Output equals oscillator frequency over twice the output divider.
// - Oscillator frequency equals reference times N.K, halved.
// - Integer multiplier is unsigned, LSB weighs one, used in both modes.
// - Fraction applies only if the fractional-mode bit is set when the loop is enabled.
// - Fraction is 24-bit unsigned, MSB weighs one half.
// - Loops run from the internal oscillator or an external reference.
// - Clock pin dividers further divide loop outputs to the clock pins.
// - System clock divider further divides the third loop output.
module dpc_dual_loop_ctrl
  import dpc_pkg::*;
#(
  parameter int N_W = DPC_N_W,
  parameter int K_W = DPC_K_W,
  parameter int OD_W = DPC_OD_W,
  parameter int PD_W = DPC_PD_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DPC_AW-1:0] paddr,
  input wire logic [DPC_DW-1:0] pwdata,
  output logic [DPC_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mclkTick,
  input wire logic oscTick,
  input wire logic fllTick,
  output logic loop2Clk,
  output logic loop3Clk,
  output logic clkOut2,
  output logic clkOut3,
  output logic systemClock
);

  localparam int NL = 2;

  logic [DPC_CTRL_W-1:0] ctrl_r;
  logic [N_W-1:0] nMul_r [NL];
  logic [NL-1:0] fracMode_r;
  logic [OD_W-1:0] outDiv_r [NL];
  logic [K_W-1:0] kMul_r [NL];
  logic [PD_W-1:0] co2Div_r, co3Div_r, sysDiv_r;
  logic [DPC_DW-1:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [NL-1:0] loopClk_r, running;
  logic clkOut2_r, clkOut3_r, system_clock_r;

  // APB decode; one wait state so read data and pready come from flops
  wire accessPh = psel & penable & ~pready_r;
  wire doWrite = psel & penable & pready_r & pwrite & ~pslverr_r;
  wire selCtrl = paddr == DPC_OFF_CTRL;
  wire selStat = paddr == DPC_OFF_STAT;
  wire selDiv = paddr == DPC_OFF_DIV;
  wire [NL-1:0] selCfg = {paddr == DPC_OFF_L3CFG, paddr == DPC_OFF_L2CFG};
  wire [NL-1:0] selK = {paddr == DPC_OFF_L3K, paddr == DPC_OFF_L2K};
  wire mapped = selCtrl | selStat | selDiv | (|selCfg) | (|selK);
  wire badAccess = ~mapped | (pwrite & selStat);

  function automatic logic [DPC_DW-1:0] cfgWord(input logic [N_W-1:0] n,
      input logic f, input logic [OD_W-1:0] od);
    logic [DPC_DW-1:0] w;
    w = '0;
    w[DPC_CFG_N_LSB +: N_W] = n;
    w[DPC_CFG_FRAC] = f;
    w[DPC_CFG_OD_LSB +: OD_W] = od;
    return w;
  endfunction

  logic [DPC_DW-1:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (selCtrl)
      rdMux[DPC_CTRL_W-1:0] = ctrl_r;
    if (selStat)
      rdMux[2*NL-1:0] = {loopClk_r, running};
    if (selDiv) begin
      rdMux[DPC_DIV_CO2_LSB +: PD_W] = co2Div_r;
      rdMux[DPC_DIV_CO3_LSB +: PD_W] = co3Div_r;
      rdMux[DPC_DIV_SYS_LSB +: PD_W] = sysDiv_r;
    end
    for (int i = 0; i < NL; i++) begin
      if (selCfg[i])
        rdMux = cfgWord(nMul_r[i], fracMode_r[i], outDiv_r[i]);
      if (selK[i])
        rdMux[K_W-1:0] = kMul_r[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= accessPh;
      pslverr_r <= accessPh & badAccess;
      if (accessPh & ~pwrite)
        prdata_r <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= DPC_CTRL_RST;
      co2Div_r <= DPC_PD_RST;
      co3Div_r <= DPC_PD_RST;
      sysDiv_r <= DPC_PD_RST;
    end else if (doWrite & selCtrl) begin
      ctrl_r <= pwdata[DPC_CTRL_W-1:0];
    end else if (doWrite & selDiv) begin
      co2Div_r <= pwdata[DPC_DIV_CO2_LSB +: PD_W];
      co3Div_r <= pwdata[DPC_DIV_CO3_LSB +: PD_W];
      sysDiv_r <= pwdata[DPC_DIV_SYS_LSB +: PD_W];
    end
  end

  // Reference choice per loop
  wire baseRef = ctrl_r[DPC_CTRL_REFSEL] ? mclkTick : oscTick;
  wire [NL-1:0] refTick = {ctrl_r[DPC_CTRL_FLL3] ? fllTick : baseRef,
                           baseRef};
  wire [NL-1:0] loopEn = {ctrl_r[DPC_CTRL_EN3], ctrl_r[DPC_CTRL_EN2]};

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : gLoop
      dpc_loop_state_t st_r, st_nxt;
      logic [DPC_ACC_W-1:0] acc_r, acc_nxt;
      logic [DPC_ACC_W-1:0] inc_r, thr_r;
      wire [DPC_ACC_W-1:0] incNow;
      wire [DPC_ACC_W-1:0] thrNow;
      wire [K_W-1:0] kEff = fracMode_r[g] ? kMul_r[g] : '0;
      // N.K in units of 2^-24; one toggle per (2*(code+1)) of N.K per ref
      assign incNow = DPC_ACC_W'({nMul_r[g], kEff});
      assign thrNow = DPC_ACC_W'({outDiv_r[g], 1'b0} + (OD_W+1)'(2))
                      << K_W;
      wire wrap = acc_r >= thr_r;

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          nMul_r[g] <= DPC_N_RST;
          fracMode_r[g] <= 1'b0;
          outDiv_r[g] <= DPC_OD_RST;
          kMul_r[g] <= DPC_K_RST;
        end else if (doWrite & selCfg[g]) begin
          nMul_r[g] <= pwdata[DPC_CFG_N_LSB +: N_W];
          fracMode_r[g] <= pwdata[DPC_CFG_FRAC];
          outDiv_r[g] <= pwdata[DPC_CFG_OD_LSB +: OD_W];
        end else if (doWrite & selK[g]) begin
          kMul_r[g] <= pwdata[K_W-1:0];
        end
      end

      // Sequencer holds start until a reference edge so phase starts aligned
      always_comb begin
        st_nxt = st_r;
        case (st_r)
          DPC_OFF: if (loopEn[g])
            st_nxt = ctrl_r[DPC_CTRL_SEQ] ? DPC_ARM : DPC_RUN;
          DPC_ARM: if (~loopEn[g])
            st_nxt = DPC_OFF;
          else if (refTick[g])
            st_nxt = DPC_RUN;
          DPC_RUN: if (~loopEn[g])
            st_nxt = DPC_OFF;
          default: st_nxt = DPC_OFF;
        endcase
      end

      // Excess phase drains one toggle per cycle, so rates average correctly
      // as long as the toggle rate stays below the system clock
      always_comb begin
        acc_nxt = acc_r;
        if (st_r == DPC_RUN) begin
          acc_nxt = acc_r - (wrap ? thr_r : '0) + (refTick[g] ? inc_r : '0);
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          st_r <= DPC_OFF;
          acc_r <= '0;
          inc_r <= '0;
          thr_r <= '0;
          loopClk_r[g] <= 1'b0;
        end else begin
          st_r <= st_nxt;
          if (st_r == DPC_OFF) begin
            acc_r <= '0;
            inc_r <= incNow;
            thr_r <= thrNow;
            loopClk_r[g] <= 1'b0;
          end else begin
            acc_r <= acc_nxt;
            if (st_r == DPC_RUN && wrap)
              loopClk_r[g] <= ~loopClk_r[g];
          end
        end
      end
      assign running[g] = st_r == DPC_RUN;
    end
  endgenerate

  // Post dividers: code 0 passes through, else divide by twice the code
  logic [NL-1:0] loopPrev_r;
  logic [PD_W-1:0] cnt2_r, cnt3_r, cntS_r;
  logic div2_r, div3_r, divS_r;
  wire [NL-1:0] loopRise = loopClk_r & ~loopPrev_r;
  wire hit2 = cnt2_r >= co2Div_r - PD_W'(1);
  wire hit3 = cnt3_r >= co3Div_r - PD_W'(1);
  wire hitS = cntS_r >= sysDiv_r - PD_W'(1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loopPrev_r <= '0;
      cnt2_r <= '0;
      cnt3_r <= '0;
      cntS_r <= '0;
      div2_r <= 1'b0;
      div3_r <= 1'b0;
      divS_r <= 1'b0;
    end else begin
      loopPrev_r <= loopClk_r;
      if (~running[0]) begin
        cnt2_r <= '0;
        div2_r <= 1'b0;
      end else if (loopRise[0]) begin
        cnt2_r <= hit2 ? '0 : cnt2_r + PD_W'(1);
        div2_r <= hit2 ? ~div2_r : div2_r;
      end
      if (~running[1]) begin
        cnt3_r <= '0;
        cntS_r <= '0;
        div3_r <= 1'b0;
        divS_r <= 1'b0;
      end else if (loopRise[1]) begin
        cnt3_r <= hit3 ? '0 : cnt3_r + PD_W'(1);
        div3_r <= hit3 ? ~div3_r : div3_r;
        cntS_r <= hitS ? '0 : cntS_r + PD_W'(1);
        divS_r <= hitS ? ~divS_r : divS_r;
      end
    end
  end

  // Outputs registered once more to keep them straight from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkOut2_r <= 1'b0;
      clkOut3_r <= 1'b0;
      system_clock_r <= 1'b0;
    end else begin
      clkOut2_r <= co2Div_r == '0 ? loopClk_r[0] : div2_r;
      clkOut3_r <= co3Div_r == '0 ? loopClk_r[1] : div3_r;
      system_clock_r <= sysDiv_r == '0 ? loopClk_r[1] : divS_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign loop2Clk = loopClk_r[0];
  assign loop3Clk = loopClk_r[1];
  assign clkOut2 = clkOut2_r;
  assign clkOut3 = clkOut3_r;
  assign systemClock = system_clock_r;

endmodule

// [verification/dpc_dual_loop_ctrl_monitor.sv]
`timescale 1ns/1ps
module dpc_dual_loop_ctrl_monitor
  import dpc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DPC_AW-1:0] paddr,
  input wire logic [DPC_DW-1:0] pwdata,
  input wire logic [DPC_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic loop2Clk,
  input wire logic loop3Clk,
  input wire logic clkOut2,
  input wire logic clkOut3
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [4:0] ctrl_r;
  // Mirror of the enables, so no internal probe is needed
  always_ff @(posedge clk) begin
    if (sys_rst) ctrl_r <= DPC_CTRL_RST;
    else if (psel && penable && pready && pwrite && paddr == DPC_OFF_CTRL)
      ctrl_r <= pwdata[4:0];
  end
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; psel && penable && pready; endsequence
  // Four cycles: state leaves run, loop clock and divider clear on the same next edge,
  // then the registered pin output follows one edge later
  sequence s_off2; !ctrl_r[0] [*4]; endsequence
  sequence s_off3; !ctrl_r[1] [*4]; endsequence
  property p_wait; s_wait |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_hole;
    s_done ##0 (!pwrite && paddr > DPC_OFF_DIV) |-> pslverr && prdata == 0;
  endproperty
  property p_ro; s_done ##0 (pwrite && paddr == DPC_OFF_STAT) |-> pslverr;
  endproperty
  property p_ctrl; s_done ##0 (!pwrite && paddr == DPC_OFF_CTRL)
    |-> !pslverr && prdata == {27'h0, ctrl_r};
  endproperty
  property p_off2; s_off2 |-> !loop2Clk && !clkOut2; endproperty
  property p_off3; s_off3 |-> !loop3Clk && !clkOut3; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  a_pulse: assert property (p_pulse) else $error("long ready");
  a_err: assert property (p_err) else $error("stray slverr");
  a_hole: assert property (p_hole) else $error("unmapped read");
  a_ro: assert property (p_ro) else $error("status written");
  a_ctrl: assert property (p_ctrl) else $error("ctrl read");
  a_off2: assert property (p_off2) else $error("loop2 not off");
  a_off3: assert property (p_off3) else $error("loop3 not off");
endmodule
bind dpc_dual_loop_ctrl dpc_dual_loop_ctrl_monitor
  dpc_dual_loop_ctrl_monitor_inst (.clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .loop2Clk,
  .loop3Clk, .clkOut2, .clkOut3);

// [verification/test_dual_pll_clock_synth_control.sv]
`timescale 1ns/1ps
module test_dual_pll_clock_synth_control
  import dpc_pkg::*;
;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic mclkTick = 0, oscTick = 0, fllTick = 0, pready, pslverr;
  logic loop2Clk, loop3Clk, clkOut2, clkOut3, systemClock;
  logic [DPC_AW-1:0] paddr = '0;
  logic [DPC_DW-1:0] pwdata = '0, prdata, rd;
  int miscompares = 0, samples_checked = 0, n[5];
  wire logic [4:0] outs = {systemClock, clkOut3, clkOut2, loop3Clk,
    loop2Clk};
  always #5 clk = ~clk;
  dpc_dual_loop_ctrl dpc_dual_loop_ctrl_inst (.clk, .sys_rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mclkTick, .oscTick, .fllTick, .loop2Clk, .loop3Clk, .clkOut2,
    .clkOut3, .systemClock);
  task automatic end_sim;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Reads in the active region see the values sampled at the edge
  task automatic apb(logic w, logic [DPC_AW-1:0] a, logic [DPC_DW-1:0] d);
    int i;
    i = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'h1 && i < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      miscompares++;
      end_sim();
    end
    @(posedge clk);
  endtask
  task automatic rc(string nm, logic [DPC_AW-1:0] a, logic [31:0] e);
    apb(1'h0, a, '0);
    chk(nm, rd, e);
    chk("slverr", err, 1'h0);
  endtask
  // Pulses one reference every fourth cycle, then lets dividers settle
  task automatic run(int src, int t);
    logic [4:0] pv;
    pv = outs;
    n = '{default: 0};
    for (int i = 0; i < t * 4 + 12; i++) begin
      {mclkTick, oscTick, fllTick} <=
        (i < t * 4 && i % 4 == 0) ? 3'h4 >> src : 3'h0;
      @(posedge clk);
      for (int b = 0; b < 5; b++) n[b] += int'(pv[b] !== outs[b]);
      pv = outs;
    end
  endtask
  task automatic cn(int e0, int e1, int e2, int e3, int e4);
    int e[5] = '{e0, e1, e2, e3, e4};
    for (int i = 0; i < 5; i++) chk($sformatf("edges%0d", i), n[i], e[i]);
  endtask
  task automatic t_reset;
    rc("ctrl", DPC_OFF_CTRL, 32'h10);
    rc("l2cfg", DPC_OFF_L2CFG, 32'h10008);
    rc("div", DPC_OFF_DIV, 32'h0);
  endtask
  task automatic t_err;
    apb(1'h0, 5'h1C, 32'hFFFFFFFF);
    chk("hole", rd, 32'h0);
    chk("hole_err", err, 1'h1);
    apb(1'h1, DPC_OFF_STAT, 32'hFFFFFFFF);
    chk("ro_err", err, 1'h1);
    apb(1'h1, DPC_OFF_L3K, 32'hFF3126E9);
    rc("k", DPC_OFF_L3K, 32'h3126E9);
  endtask
  task automatic t_clk;
    apb(1'h1, DPC_OFF_L2CFG, 32'h30008);
    apb(1'h1, DPC_OFF_L3CFG, 32'h30008);
    apb(1'h1, DPC_OFF_DIV, 32'h10302);
    apb(1'h1, DPC_OFF_CTRL, 32'hB);
    run(1, 12);
    cn(12, 0, 3, 0, 0);
    run(2, 12);
    cn(0, 12, 0, 2, 6);
    apb(1'h1, DPC_OFF_CTRL, 32'h7);
    run(1, 4);
    cn(0, 0, 0, 0, 0);
    run(0, 4);
    chk("mclk2", n[0], 4);
    chk("mclk3", n[1], 4);
  endtask
  task automatic t_frac;
    apb(1'h1, DPC_OFF_CTRL, 32'h0);
    chk("off", loop2Clk, 1'h0);
    apb(1'h1, DPC_OFF_L2CFG, 32'h40105);
    apb(1'h1, DPC_OFF_L2K, 32'h800000);
    apb(1'h1, DPC_OFF_CTRL, 32'h1);
    run(1, 21);
    chk("frac", n[0], 11);
    apb(1'h1, DPC_OFF_L2CFG, 32'h40005);
    run(1, 21);
    chk("held", n[0], 12);
    apb(1'h1, DPC_OFF_CTRL, 32'h0);
    apb(1'h1, DPC_OFF_CTRL, 32'h1);
    run(1, 21);
    chk("int", n[0], 10);
  endtask
  task automatic t_seq;
    apb(1'h1, DPC_OFF_CTRL, 32'h0);
    apb(1'h1, DPC_OFF_CTRL, 32'h11);
    rc("armed", DPC_OFF_STAT, 32'h0);
    run(1, 1);
    rc("running", DPC_OFF_STAT, 32'h1);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_err();
    t_clk();
    t_frac();
    t_seq();
    end_sim();
  end
endmodule
